//--- logic/rsc_consts.vh
// constants for the reset strap configuration block
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH
// register addresses
`define RSC_POS_ID_LO 12'h100
`define RSC_POS_ID_HI 12'h101
`define RSC_POS_CARD_EN 12'h102
`define RSC_EC2_ADDR 12'h800
`define RSC_EC3_ADDR 12'h802
`define RSC_SUBSYS_ADDR 12'h804
`define RSC_DISP_ADDR 12'h806
`define RSC_SUBCTL_ADDR 12'h808
`define RSC_MEMCTL_ADDR 12'h80a
// field positions in extended_config_two
`define RSC_EC2_DAC 13
`define RSC_EC2_VRAM1M 10
`define RSC_EC2_BANK_HI 9
`define RSC_EC2_BANK_LO 8
`define RSC_EC2_PLANE 7
`define RSC_EC2_ROMPG 6
`define RSC_EC2_ROMSZ 5
`define RSC_EC2_BASE_HI 4
`define RSC_EC2_BASE_LO 3
// field positions elsewhere
`define RSC_EC3_MID_HI 15
`define RSC_EC3_MID_LO 13
`define RSC_SUB_PLANE 7
`define RSC_SUB_MID_HI 6
`define RSC_SUB_MID_LO 4
`define RSC_DISP_SENSE 0
`define RSC_CARD_EN_BIT 0
`define RSC_SUBCTL_SRST_HI 15
`define RSC_SUBCTL_SRST_LO 14
// bank count encodings
`define RSC_BANKS_1 2'h0
`define RSC_BANKS_2 2'h1
`define RSC_BANKS_4 2'h2
// rom window bases, address bits 19:13
`define RSC_BASE_D8000 7'h6c
`define RSC_BASE_C0000 7'h60
`define RSC_BASE_C8000 7'h64
`define RSC_BASE_C6000 7'h63
// reset values of non-strap registers
`define RSC_EC3_RST 16'h0000
`define RSC_MEMCTL_RST 16'h0000
`define RSC_CARD_EN_RST 1'h0
`endif

//--- logic/rsc_reset_strap_config.v
// reset strap capture, configuration registers and bus lane decode
// Function
// - capture all strap pins on the third clock after hardware reset is released
// - tristate all outputs during hardware reset except reset output
// - straps pulled up read 1; board drives low during reset for 0
// - counters held cleared while hardware reset is asserted
// - soft reset resets registers and reloads latched straps, but no tristate, counters or strap recapture
// - setup read of ids 100h/101h asserts rom select, id buffer, page ones
// - card enable at 102h bit 0, read/write, only while setup low
// - option registers byte access only, absent in isa mode
// - a0 and byte-high-enable decode to lanes as tabled
// - grounded setup selects isa; variant strap low selects unlatched isa
// - vram bit 8 strap picks 1mb or 256kb, held in ec2 bit 10
// - high column strobes strap bank count, held in ec2 bits 9:8
// - interleave fields per vram type; low horizontal bit picks nugget (no interleave or nugget logic here)
// - dac width pin latched at reset, driven back, held in ec2 bit 13
// - sense in display status bit 0, monitor ids in status 6:4
// - with rom paging, ids latched into ec3 15:13; paging in ec2 6
// - nibble strap low enables five extra memory signals
// - only pixel bits 7..3 are options; 2..0 reserved or write enables
// - pixel bit 7 gives plane count, in status bit 7 and ec2 bit 7
// - pixel bit 5 high selects 8k rom window, low 32k
// - rom select low at reset disables the rom window
// - pixel bits 4:3 select rom base per table
`timescale 1ns/1ps
`include "rsc_consts.vh"
module rsc_reset_strap_config (
	// clock and reset
	input wire clk_i,
	input wire rstn_i,
	// strap and sense pins
	input wire dac_width_sel_i,
	input wire rom_select_n_i,
	input wire vram_addr_bit8_i,
	input wire [1:0] bank_col_strobe_hi_n_i,
	input wire bus_variant_strap_i,
	input wire nibble_strap_n_i,
	input wire [7:0] pixel_bus_plane_byte_i,
	input wire setup_n_i,
	input wire monitor_sense_i,
	input wire [2:0] monitor_id_pins_i,
	// host register access
	input wire [11:0] addr_i,
	input wire byte_high_en_n_i,
	input wire rd_i,
	input wire wr_i,
	input wire [15:0] wdata_i,
	output reg [15:0] rdata_o,
	output wire lane_lo_o,
	output wire lane_hi_o,
	output wire swap_odd_o,
	// pins driven out
	output wire reset_out_n_o,
	output wire dac_width_sel_o,
	output wire dac_width_sel_oe_o,
	output wire rom_select_n_o,
	output wire id_buffer_enable_n_o,
	output wire [2:0] rom_page_sel_o,
	output wire pins_oe_o,
	// decoded configuration
	output wire isa_mode_o,
	output wire unlatched_isa_mode_o,
	output wire nibble_mode_o,
	output wire rom_window_en_o,
	output wire rom_window_size_o,
	output wire [6:0] rom_window_base_o,
	output wire [1:0] bank_count_o,
	output wire vram_1mb_o,
	output wire card_enable_o,
	output wire soft_reset_o,
	output wire [7:0] cycle_count_o
);

	// ----------------------------------------------------------------
	// reset path and strap capture
	// ----------------------------------------------------------------
	// straps are taken on the third clock after release, once the pin
	// values have crossed both synchroniser flops; the board keeps its
	// strap drivers on until then, so the capture never sees a pin that
	// is still settling or already reused for its run-time function.
	reg [1:0] rst_sync;
	reg [17:0] pin_s1;
	reg [17:0] pin_s2;
	reg strap_done;
	reg [15:0] strap_ec2;
	reg rom_absent;
	reg isa_strap;
	reg unlatched_isa_mode_strap;
	reg nibble_strap;
	reg [2:0] mid_strap;
	reg [7:0] cnt;
	wire [17:0] pin_raw;

	assign pin_raw = {monitor_id_pins_i, setup_n_i, nibble_strap_n_i,
		bus_variant_strap_i, pixel_bus_plane_byte_i[7:3],
		bank_col_strobe_hi_n_i, vram_addr_bit8_i, rom_select_n_i,
		dac_width_sel_i, monitor_sense_i, 1'b0};

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_s1 <= 18'h00000;
			pin_s2 <= 18'h00000;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
		end
	end

	wire [2:0] s_mid = pin_s2[17:15];
	wire s_setup_n = pin_s2[14];
	wire s_nibble_n = pin_s2[13];
	wire s_variant = pin_s2[12];
	wire [4:0] s_pix = pin_s2[11:7];
	wire [1:0] s_cas = pin_s2[6:5];
	wire s_ma8 = pin_s2[4];
	wire s_rom_select_n_n = pin_s2[3];
	wire s_dac = pin_s2[2];
	wire s_sense = pin_s2[1];

	// strap pins are settled two clocks after release
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	// bank code from the two high column strobes
	reg [1:0] bank_code;
	always @* begin
		case (s_cas)
			2'b00: bank_code = `RSC_BANKS_1;
			// only the high strobe pulled low marks two banks
			2'b01: bank_code = `RSC_BANKS_2;
			default: bank_code = `RSC_BANKS_4;
		endcase
	end

	// strap word as it lands in extended_config_two; the paging bit and
	// the reserved fields stay 0 because no strap feeds them
	reg [15:0] cap_ec2;
	always @* begin
		cap_ec2 = 16'h0000;
		cap_ec2[`RSC_EC2_DAC] = s_dac;
		cap_ec2[`RSC_EC2_VRAM1M] = s_ma8;
		cap_ec2[`RSC_EC2_BANK_HI:`RSC_EC2_BANK_LO] = bank_code;
		cap_ec2[`RSC_EC2_PLANE] = s_pix[4];
		cap_ec2[`RSC_EC2_ROMSZ] = s_pix[2];
		cap_ec2[`RSC_EC2_BASE_HI:`RSC_EC2_BASE_LO] = s_pix[1:0];
	end

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strap_done <= 1'b0;
			strap_ec2 <= 16'h0000;
			rom_absent <= 1'b0;
			isa_strap <= 1'b0;
			unlatched_isa_mode_strap <= 1'b0;
			nibble_strap <= 1'b0;
			mid_strap <= 3'h0;
		end else if (rst_sync[1] && !strap_done) begin
			strap_done <= 1'b1;
			strap_ec2 <= cap_ec2;
			rom_absent <= ~s_rom_select_n_n;
			isa_strap <= ~s_setup_n;
			unlatched_isa_mode_strap <= ~s_variant;
			nibble_strap <= ~s_nibble_n;
			mid_strap <= s_mid;
		end
	end

	// pins float until straps are taken
	assign pins_oe_o = strap_done;
	assign reset_out_n_o = strap_done;

	// counters cleared only by hardware reset
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= 8'h00;
		end else if (strap_done) begin
			cnt <= cnt + 8'h01;
		end
	end
	assign cycle_count_o = cnt;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire a0 = addr_i[0];
	assign lane_lo_o = ~a0 | byte_high_en_n_i;
	assign lane_hi_o = byte_high_en_n_i ? 1'b0 : 1'b1;
	assign swap_odd_o = a0 & byte_high_en_n_i;
	wire byte_acc = a0 | byte_high_en_n_i;
	// the low byte always rides on the low lane; the high byte comes from
	// the high lane except for an odd byte swapped onto the low lane
	wire [7:0] wbyte_lo = wdata_i[7:0];
	wire [7:0] wbyte_hi = swap_odd_o ? wdata_i[7:0] : wdata_i[15:8];

	wire setup_act = ~s_setup_n & ~isa_strap;
	// option registers only as bytes and never in isa mode
	wire pos_ok = byte_acc & ~isa_strap & ~unlatched_isa_mode_strap & setup_act;
	wire id_rd = rd_i & pos_ok & ((addr_i == `RSC_POS_ID_LO) |
		(addr_i == `RSC_POS_ID_HI));

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg [15:0] ec2;
	reg [15:0] ec3;
	reg [15:0] memctl;
	reg [1:0] srst_field;
	reg card_en;
	wire soft_rst = |srst_field;

	wire sel_ec2 = {addr_i[11:1], 1'b0} == `RSC_EC2_ADDR;
	wire sel_ec3 = {addr_i[11:1], 1'b0} == `RSC_EC3_ADDR;
	wire sel_sub = {addr_i[11:1], 1'b0} == `RSC_SUBSYS_ADDR;
	wire sel_disp = {addr_i[11:1], 1'b0} == `RSC_DISP_ADDR;
	wire sel_ctl = {addr_i[11:1], 1'b0} == `RSC_SUBCTL_ADDR;
	wire sel_mem = {addr_i[11:1], 1'b0} == `RSC_MEMCTL_ADDR;
	wire we_lo = wr_i & (~a0);
	wire we_hi = wr_i & (a0 | ~byte_high_en_n_i);

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			srst_field <= 2'h0;
		end else if (wr_i && sel_ctl && we_hi) begin
			srst_field <= wbyte_hi[7:6];
		end
	end

	// soft reset reloads latched straps, no pin or counter effect
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ec2 <= 16'h0000;
			ec3 <= `RSC_EC3_RST;
			memctl <= `RSC_MEMCTL_RST;
			card_en <= `RSC_CARD_EN_RST;
		end else if (soft_rst || (rst_sync[1] && !strap_done)) begin
			// on the capture clock the fresh strap word goes straight in
			ec2 <= strap_done ? strap_ec2 : cap_ec2;
			ec3 <= `RSC_EC3_RST;
			memctl <= `RSC_MEMCTL_RST;
			card_en <= `RSC_CARD_EN_RST;
		end else if (strap_done) begin
			if (!ec2[`RSC_EC2_ROMPG] || ec3 == `RSC_EC3_RST)
				ec3[`RSC_EC3_MID_HI:`RSC_EC3_MID_LO] <= mid_strap;
			if (sel_ec2 && we_lo) ec2[7:0] <= wbyte_lo;
			if (sel_ec2 && we_hi) ec2[15:8] <= wbyte_hi;
			if (sel_ec3 && we_lo) ec3[7:0] <= wbyte_lo;
			if (sel_ec3 && we_hi) ec3[15:8] <= wbyte_hi;
			if (sel_mem && we_lo) memctl[7:0] <= wbyte_lo;
			if (sel_mem && we_hi) memctl[15:8] <= wbyte_hi;
			if (wr_i && pos_ok && addr_i == `RSC_POS_CARD_EN)
				card_en <= wbyte_lo[`RSC_CARD_EN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	reg [15:0] rd_word;
	always @* begin
		rd_word = 16'h0000;
		if (sel_ec2)
			rd_word = ec2;
		else if (sel_ec3)
			rd_word = ec3;
		else if (sel_sub)
			rd_word = {8'h00, ec2[`RSC_EC2_PLANE],
				ec2[`RSC_EC2_ROMPG] ? ec3[15:13] : s_mid, 4'h0};
		else if (sel_disp)
			rd_word = {15'h0000, s_sense};
		else if (sel_mem)
			rd_word = memctl;
		else if (pos_ok && addr_i == `RSC_POS_CARD_EN)
			rd_word = {15'h0000, card_en};
	end

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			// odd byte moved to low lane when swapping
			rdata_o <= swap_odd_o ? {8'h00, rd_word[15:8]} : rd_word;
		end
	end

	// ----------------------------------------------------------------
	// decoded outputs
	// ----------------------------------------------------------------
	// id read forces rom select and page ones
	assign rom_select_n_o = ~id_rd;
	assign id_buffer_enable_n_o = ~id_rd;
	assign rom_page_sel_o = id_rd ? 3'h7 : 3'h0;
	// dac width driven back after reset
	assign dac_width_sel_o = ec2[`RSC_EC2_DAC];
	assign dac_width_sel_oe_o = strap_done;
	assign isa_mode_o = isa_strap;
	assign unlatched_isa_mode_o = unlatched_isa_mode_strap;
	assign nibble_mode_o = nibble_strap;
	assign rom_window_en_o = ~rom_absent & strap_done;
	assign rom_window_size_o = ec2[`RSC_EC2_ROMSZ];
	reg [6:0] base;
	always @* begin
		case (ec2[`RSC_EC2_BASE_HI:`RSC_EC2_BASE_LO])
			2'b01: base = `RSC_BASE_D8000;
			2'b10: base = `RSC_BASE_C0000;
			2'b11: base = (ec2[`RSC_EC2_ROMSZ] && !isa_strap &&
				!unlatched_isa_mode_strap) ? `RSC_BASE_C6000 : `RSC_BASE_C8000;
			default: base = `RSC_BASE_C8000;
		endcase
	end
	assign rom_window_base_o = base;
	assign bank_count_o = ec2[`RSC_EC2_BANK_HI:`RSC_EC2_BANK_LO];
	assign vram_1mb_o = ec2[`RSC_EC2_VRAM1M];
	assign card_enable_o = card_en;
	assign soft_reset_o = soft_rst;

endmodule // rsc_reset_strap_config

//--- sim/rsc_reset_strap_config_monitor.sv
// port checks for the reset strap configuration block
`timescale 1ns/1ps
module rsc_reset_strap_config_monitor (
	// clock and reset
	input wire clk_i,
	input wire rstn_i,
	// host side
	input wire [11:0] addr_i,
	input wire byte_high_en_n_i,
	input wire rd_i,
	// outputs
	input wire lane_hi_o,
	input wire swap_odd_o,
	input wire reset_out_n_o,
	input wire pins_oe_o,
	input wire dac_width_sel_oe_o,
	input wire rom_select_n_o,
	input wire id_buffer_enable_n_o,
	input wire [2:0] rom_page_sel_o,
	input wire soft_reset_o,
	input wire [7:0] cycle_count_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	lane_hi_a: assert property (
		lane_hi_o == !byte_high_en_n_i)
		else $error("bad high lane");
	odd_swap_a: assert property (
		swap_odd_o == (addr_i[0] && byte_high_en_n_i))
		else $error("bad odd swap");
	reset_tri_a: assert property (disable iff (1'b0)
		!rstn_i |-> !pins_oe_o && !reset_out_n_o && !dac_width_sel_oe_o)
		else $error("pins driven in reset");
	count_clear_a: assert property (disable iff (1'b0)
		!rstn_i |-> cycle_count_o == 8'h00)
		else $error("counter not clear");
	capture_time_a: assert property (
		$rose(rstn_i) |-> (!pins_oe_o && !reset_out_n_o) [*3]
		##1 (pins_oe_o && reset_out_n_o))
		else $error("bad capture timing");
	id_read_a: assert property (
		!id_buffer_enable_n_o |-> !rom_select_n_o && rd_i
		&& rom_page_sel_o == 3'h7 && addr_i[11:1] == 11'h080)
		else $error("bad id read");
	soft_keep_a: assert property (
		soft_reset_o |-> pins_oe_o && reset_out_n_o)
		else $error("soft reset tristated");
	dac_drive_a: assert property (
		dac_width_sel_oe_o == pins_oe_o)
		else $error("dac pin not driven");
endmodule // rsc_reset_strap_config_monitor
bind rsc_reset_strap_config rsc_reset_strap_config_monitor mon (.clk_i,
	.rstn_i, .addr_i, .byte_high_en_n_i, .rd_i, .lane_hi_o, .swap_odd_o,
	.reset_out_n_o, .pins_oe_o, .dac_width_sel_oe_o, .rom_select_n_o,
	.id_buffer_enable_n_o, .rom_page_sel_o, .soft_reset_o, .cycle_count_o);

//--- sim/rsc_strap_board.sv
// board jumpers and pull resistors on the strap pins
`timescale 1ns/1ps
module rsc_strap_board (
	// control
	input wire reset_out_n_i,
	input wire [11:0] jumper_i,
	// strap pins
	output wire [11:0] strap_o,
	output wire [7:0] pixel_o
);
	// jumper drivers
	// drivers on bits 10:0 are enabled by the reset output, pull-ups win after; bit 11 is always driven
	assign strap_o[10:0] = reset_out_n_i ? 11'h7ff : jumper_i[10:0];
	assign strap_o[11] = jumper_i[11];
	assign pixel_o = {strap_o[4:0], 3'h7};
endmodule // rsc_strap_board

//--- sim/tb_top.sv
// self-checking bench for the reset strap configuration block
`timescale 1ns/1ps
`include "rsc_consts.vh"
module tb_top;
	typedef struct packed {
		logic [11:0] jmp;
		logic su;
		logic [15:0] ec2;
		logic [6:0] base;
		logic [7:0] flg;
	} rsc_row_t;
	// jumpers, setup, ec2, base, {isa,unlatched_isa_mode,nibble,rom_en,size,1mb,banks}
	rsc_row_t rows [6] = '{
		'{12'hfff, 1'b1, 16'h26b8, 7'h63, 8'h1e},
		'{12'hffe, 1'b0, 16'h26b0, 7'h60, 8'h9e},
		'{12'heff, 1'b0, 16'h25b8, 7'h64, 8'h9d},
		'{12'h001, 1'b0, 16'h0008, 7'h6c, 8'he0},
		'{12'hfbf, 1'b1, 16'h26b8, 7'h64, 8'h5e},
		'{12'hff3, 1'b1, 16'h2698, 7'h64, 8'h16}};
	logic clk_i, rstn_i, setup_n_i, monitor_sense_i;
	logic byte_high_en_n_i, rd_i, wr_i;
	logic [2:0] monitor_id_pins_i;
	logic [11:0] addr_i, jmp;
	logic [15:0] wdata_i, d;
	wire [15:0] rdata_o;
	wire [11:0] st;
	wire [7:0] pix, cycle_count_o;
	wire [6:0] rom_window_base_o;
	wire [2:0] rom_page_sel_o;
	wire [1:0] bank_count_o;
	wire lane_lo_o, lane_hi_o, swap_odd_o, reset_out_n_o, dac_width_sel_o;
	wire dac_width_sel_oe_o, rom_select_n_o, id_buffer_enable_n_o, pins_oe_o;
	wire isa_mode_o, unlatched_isa_mode_o, nibble_mode_o, rom_window_en_o;
	wire rom_window_size_o, vram_1mb_o, card_enable_o, soft_reset_o;
	wire [7:0] flags = {isa_mode_o, unlatched_isa_mode_o, nibble_mode_o,
		rom_window_en_o, rom_window_size_o, vram_1mb_o, bank_count_o};
	// the device takes the pin back once straps are captured
	wire dac = dac_width_sel_oe_o ? dac_width_sel_o : st[11];
	int errors, comparisons;
	rsc_strap_board board (.reset_out_n_i(reset_out_n_o), .jumper_i(jmp),
		.strap_o(st), .pixel_o(pix));
	rsc_reset_strap_config DUT (.clk_i, .rstn_i, .dac_width_sel_i(dac),
		.rom_select_n_i(st[10]), .vram_addr_bit8_i(st[9]),
		.bank_col_strobe_hi_n_i(st[8:7]), .bus_variant_strap_i(st[6]),
		.nibble_strap_n_i(st[5]), .pixel_bus_plane_byte_i(pix),
		.setup_n_i, .monitor_sense_i, .monitor_id_pins_i, .addr_i,
		.byte_high_en_n_i, .rd_i, .wr_i, .wdata_i, .rdata_o, .lane_lo_o,
		.lane_hi_o, .swap_odd_o, .reset_out_n_o, .dac_width_sel_o,
		.dac_width_sel_oe_o, .rom_select_n_o, .id_buffer_enable_n_o,
		.rom_page_sel_o, .pins_oe_o, .isa_mode_o, .unlatched_isa_mode_o,
		.nibble_mode_o, .rom_window_en_o, .rom_window_size_o,
		.rom_window_base_o, .bank_count_o, .vram_1mb_o, .card_enable_o,
		.soft_reset_o, .cycle_count_o);
	task chk(input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task summarize;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic b, input logic [15:0] v);
		addr_i = a;
		byte_high_en_n_i = b;
		wdata_i = v;
		wr_i = 1;
		@(negedge clk_i);
		wr_i = 0;
		@(negedge clk_i);
	endtask
	task rd(input logic [11:0] a, output logic [15:0] v);
		addr_i = a;
		byte_high_en_n_i = 0;
		rd_i = 1;
		@(negedge clk_i);
		rd_i = 0;
		v = rdata_o;
		@(negedge clk_i);
	endtask
	task boot(input logic [11:0] j, input logic s);
		jmp = j;
		setup_n_i = s;
		rstn_i = 0;
		repeat (4) @(negedge clk_i);
		chk({pins_oe_o, reset_out_n_o, cycle_count_o}, 0);
		rstn_i = 1;
		repeat (6) @(negedge clk_i);
	endtask
	initial begin
		clk_i = 0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		errors++;
		summarize;
	end
	initial begin
		{rstn_i, setup_n_i, monitor_sense_i, rd_i, wr_i} = '0;
		{byte_high_en_n_i, monitor_id_pins_i, addr_i, wdata_i} = '0;
		jmp = '1;
		foreach (rows[i]) begin
			boot(rows[i].jmp, rows[i].su);
			rd(`RSC_EC2_ADDR, d);
			chk(d, rows[i].ec2);
			chk(flags, rows[i].flg);
			chk(rom_window_base_o, rows[i].base);
			chk(dac_width_sel_o, rows[i].ec2[13]);
			setup_n_i = 0;
			repeat (3) @(negedge clk_i);
			wr(`RSC_POS_CARD_EN, 1, 16'h0001);
			chk(card_enable_o, !(rows[i].flg[7] | rows[i].flg[6]));
		end
		wr(`RSC_POS_CARD_EN, 0, 16'h0000);
		chk(card_enable_o, 1);
		setup_n_i = 1;
		repeat (3) @(negedge clk_i);
		wr(`RSC_POS_CARD_EN, 1, 16'h0000);
		chk(card_enable_o, 1);
		setup_n_i = 0;
		repeat (3) @(negedge clk_i);
		addr_i = `RSC_POS_ID_HI;
		byte_high_en_n_i = 1;
		rd_i = 1;
		#1;
		chk({id_buffer_enable_n_o, rom_select_n_o, rom_page_sel_o}, 7);
		chk(swap_odd_o, 1);
		chk({lane_lo_o, lane_hi_o}, 2'h2);
		@(negedge clk_i);
		rd_i = 0;
		wr(`RSC_EC2_ADDR, 0, 16'h0108);
		rd(`RSC_EC2_ADDR, d);
		chk(d, 16'h0108);
		chk({vram_1mb_o, bank_count_o, rom_window_base_o}, 10'h0ec);
		chk(dac_width_sel_o, 0);
		wr(`RSC_MEMCTL_ADDR, 0, 16'h00a5);
		rd(`RSC_MEMCTL_ADDR, d);
		chk(d, 16'h00a5);
		monitor_sense_i = 1;
		monitor_id_pins_i = 3'h5;
		repeat (3) @(negedge clk_i);
		rd(`RSC_DISP_ADDR, d);
		chk(d[0], 1);
		rd(`RSC_SUBSYS_ADDR, d);
		chk(d[6:4], 3'h5);
		rd(`RSC_EC3_ADDR, d);
		chk(d[15:13], 3'h0);
		wr(`RSC_SUBCTL_ADDR, 0, 16'hc000);
		chk(soft_reset_o, 1);
		rd(`RSC_EC2_ADDR, d);
		chk(d, 16'h2698);
		wr(`RSC_SUBCTL_ADDR, 0, 16'h0000);
		rd(`RSC_SUBSYS_ADDR, d);
		chk({soft_reset_o, d[7]}, 2'h1);
		summarize;
	end
endmodule // tb_top
